/* File: verilog/mpsl_defines.vh */
/*
 * Constants of the management pin block: reset wait, frame layout,
 * strap positions.
 * Assumes it is included by bare name from files under verilog/.
 */
`ifndef MPSL_DEFINES_VH
`define MPSL_DEFINES_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MPSL_CLK_MHZ 200
`define MPSL_RST_WAIT_US 400
`define MPSL_RST_WAIT_CYC (`MPSL_RST_WAIT_US * `MPSL_CLK_MHZ)

// ----------------------------------------------------------------
// management frame layout
// ----------------------------------------------------------------
`define MPSL_HDR_BITS 5'h0E
`define MPSL_TAIL_BITS 5'h12
`define MPSL_DATA_BITS 5'h10
`define MPSL_ST_CODE 2'h1
`define MPSL_OP_WRITE 2'h1
`define MPSL_OP_READ 2'h2
`define MPSL_ST_HI 13
`define MPSL_ST_LO 12
`define MPSL_OP_HI 11
`define MPSL_OP_LO 10
`define MPSL_PA_HI 9
`define MPSL_PA_LO 5
`define MPSL_RA_HI 4
`define MPSL_RA_LO 0

// ----------------------------------------------------------------
// synchroniser lanes
// ----------------------------------------------------------------
`define MPSL_SYNC_W 7
`define MPSL_LN_MDC 0
`define MPSL_LN_MDIO 1
`define MPSL_LN_STRAP_LO 2
`define MPSL_LN_STRAP_HI 6

`endif

/* File: verilog/mpsl_sync2.v */
/*
 * Two-flop synchroniser, one lane per bit.
 * Assumes each lane is an independent level from outside clk_sys.
 */
`timescale 1ns/1ps
module mpsl_sync2 #(
    parameter WIDTH = 1
) (
    // clock
    input wire clk_sys,
    // lanes
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // first stage feeds only the second
    always @(posedge clk_sys) begin
        meta_q <= asyncIn;
        sync_q <= meta_q;
    end

    assign syncOut = sync_q;
endmodule // mpsl_sync2

/* File: verilog/mpsl_mgmt_top.v */
/*
 * Management pin block: serial management slave on the sampled
 * management clock, address straps caught after reset, and the
 * strapped-polarity indicator outputs.
 * Assumes link and activity status come from logic on clk_sys and
 * a register file answers regRdData on clk_sys.
 */
`timescale 1ns/1ps
`include "mpsl_defines.vh"
module mpsl_mgmt_top #(
    parameter RST_WAIT_CYC = `MPSL_RST_WAIT_CYC,
    parameter CNT_W = 17
) (
    // clock and reset
    input wire clk_sys,
    input wire srst,
    // management link pins
    input wire mdcIn,
    input wire mdioIn,
    output wire mdioOut,
    output wire mdioOeN,
    // strap and indicator pins
    input wire linkIndicatorIn,
    input wire activityIndicatorIn,
    input wire speedIndicatorIn,
    input wire duplexIndicatorIn,
    input wire phyAddrStrap4In,
    output wire linkIndicatorOut,
    output wire linkIndicatorOeN,
    output wire activityIndicatorOut,
    output wire activityIndicatorOeN,
    output wire speedIndicatorOut,
    output wire speedIndicatorOeN,
    output wire duplexIndicatorOut,
    output wire duplexIndicatorOeN,
    // status from the transceiver core
    input wire linkGood,
    input wire txActive,
    input wire rxActive,
    input wire speed100,
    input wire fullDuplex,
    // register file side
    output wire [4:0] regAddr,
    output wire regRdStrobe,
    input wire [15:0] regRdData,
    output wire [15:0] regWrData,
    output wire regWrStrobe,
    // state
    output wire [4:0] phyAddress,
    output wire deviceReady
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_HDR = 6'h02;
    localparam [5:0] S_RTA = 6'h04;
    localparam [5:0] S_RDAT = 6'h08;
    localparam [5:0] S_WR = 6'h10;
    localparam [5:0] S_SKIP = 6'h20;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire [`MPSL_SYNC_W-1:0] syncIn;
    wire mdcS;
    wire mdioS;
    wire [4:0] strapS;

    mpsl_sync2 #(.WIDTH(`MPSL_SYNC_W)) uSync (
        .clk_sys(clk_sys),
        .asyncIn({phyAddrStrap4In, duplexIndicatorIn, speedIndicatorIn,
            activityIndicatorIn, linkIndicatorIn, mdioIn, mdcIn}),
        .syncOut(syncIn)
    );
    assign mdcS = syncIn[`MPSL_LN_MDC];
    assign mdioS = syncIn[`MPSL_LN_MDIO];
    assign strapS = syncIn[`MPSL_LN_STRAP_HI:`MPSL_LN_STRAP_LO];

    // ------------------------------------------------------------
    // reset wait and strap capture
    // ------------------------------------------------------------
    reg [CNT_W-1:0] waitCnt_q;
    reg ready_q;
    reg [4:0] strap_q;

    // pins are released while waiting so the straps can be read
    always @(posedge clk_sys) begin
        if (srst) begin
            waitCnt_q <= {CNT_W{1'b0}};
            ready_q <= 1'b0;
            strap_q <= 5'h00;
        end else if (!ready_q) begin
            if (waitCnt_q == RST_WAIT_CYC[CNT_W-1:0] - 1'b1) begin
                ready_q <= 1'b1;
                strap_q <= strapS;
            end else begin
                waitCnt_q <= waitCnt_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // indicators: xor with strap flips to active-low when high
    // ------------------------------------------------------------
    reg [3:0] ind_q;
    reg indOe_q;
    wire [3:0] indEvent;

    assign indEvent = {fullDuplex & linkGood, speed100,
        txActive | rxActive, linkGood};

    always @(posedge clk_sys) begin
        if (srst) begin
            ind_q <= 4'h0;
            indOe_q <= 1'b0;
        end else begin
            ind_q <= indEvent ^ strap_q[3:0];
            // enable one edge late so no pulse of the old polarity leaks
            indOe_q <= ready_q;
        end
    end

    assign linkIndicatorOut = ind_q[0];
    assign activityIndicatorOut = ind_q[1];
    assign speedIndicatorOut = ind_q[2];
    assign duplexIndicatorOut = ind_q[3];
    assign linkIndicatorOeN = ~indOe_q;
    assign activityIndicatorOeN = ~indOe_q;
    assign speedIndicatorOeN = ~indOe_q;
    assign duplexIndicatorOeN = ~indOe_q;

    // ------------------------------------------------------------
    // management frame engine
    // ------------------------------------------------------------
    reg mdcPrev_q;
    wire mdcRise;
    reg [5:0] state_q, state_d;
    reg [4:0] cnt_q, cnt_d;
    reg [13:0] hdr_q, hdr_d;
    reg [15:0] sh_q, sh_d;
    reg [4:0] addr_q, addr_d;
    reg [15:0] wrData_q, wrData_d;
    reg wrStb_q, wrStb_d;
    reg rdStb_q, rdStb_d;
    reg out_q, out_d;
    reg oeN_q, oeN_d;
    wire [13:0] hdrNext;
    wire hdrOk;

    // only rising management clock edges move the engine
    assign mdcRise = mdcS & ~mdcPrev_q;
    assign hdrNext = {hdr_q[12:0], mdioS};
    assign hdrOk = hdrNext[`MPSL_ST_HI:`MPSL_ST_LO] == `MPSL_ST_CODE &&
        hdrNext[`MPSL_PA_HI:`MPSL_PA_LO] == strap_q;

    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        hdr_d = hdr_q;
        sh_d = sh_q;
        addr_d = addr_q;
        wrData_d = wrData_q;
        wrStb_d = 1'b0;
        rdStb_d = 1'b0;
        out_d = out_q;
        oeN_d = oeN_q;
        if (mdcRise && ready_q) begin
            case (state_q)
                S_IDLE: begin
                    // preamble may be suppressed: first zero is start
                    if (!mdioS) begin
                        hdr_d = hdrNext;
                        cnt_d = 5'h01;
                        state_d = S_HDR;
                    end
                end
                S_HDR: begin
                    hdr_d = hdrNext;
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == `MPSL_HDR_BITS - 1'b1) begin
                        cnt_d = 5'h00;
                        addr_d = hdrNext[`MPSL_RA_HI:`MPSL_RA_LO];
                        state_d = S_SKIP;
                        if (hdrOk && hdrNext[`MPSL_OP_HI:`MPSL_OP_LO] ==
                            `MPSL_OP_READ) begin
                            rdStb_d = 1'b1;
                            state_d = S_RTA;
                        end else if (hdrOk && hdrNext[`MPSL_OP_HI:
                            `MPSL_OP_LO] == `MPSL_OP_WRITE) begin
                            state_d = S_WR;
                        end
                    end
                end
                S_RTA: begin
                    // second turnaround bit is driven low by us
                    out_d = 1'b0;
                    oeN_d = 1'b0;
                    sh_d = regRdData;
                    state_d = S_RDAT;
                end
                S_RDAT: begin
                    if (cnt_q == `MPSL_DATA_BITS) begin
                        oeN_d = 1'b1;
                        out_d = 1'b0;
                        cnt_d = 5'h00;
                        state_d = S_IDLE;
                    end else begin
                        out_d = sh_q[15];
                        sh_d = {sh_q[14:0], 1'b0};
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                S_WR: begin
                    // turnaround bits shift through and fall off
                    sh_d = {sh_q[14:0], mdioS};
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == `MPSL_TAIL_BITS - 1'b1) begin
                        wrData_d = {sh_q[14:0], mdioS};
                        wrStb_d = 1'b1;
                        cnt_d = 5'h00;
                        state_d = S_IDLE;
                    end
                end
                S_SKIP: begin
                    // frames for another address pass unanswered
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == `MPSL_TAIL_BITS - 1'b1) begin
                        cnt_d = 5'h00;
                        state_d = S_IDLE;
                    end
                end
                default: begin
                    cnt_d = 5'h00;
                    oeN_d = 1'b1;
                    state_d = S_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            mdcPrev_q <= 1'b0;
            state_q <= S_IDLE;
            cnt_q <= 5'h00;
            hdr_q <= 14'h0000;
            sh_q <= 16'h0000;
            addr_q <= 5'h00;
            wrData_q <= 16'h0000;
            wrStb_q <= 1'b0;
            rdStb_q <= 1'b0;
            out_q <= 1'b0;
            oeN_q <= 1'b1;
        end else begin
            mdcPrev_q <= mdcS;
            state_q <= state_d;
            cnt_q <= cnt_d;
            hdr_q <= hdr_d;
            sh_q <= sh_d;
            addr_q <= addr_d;
            wrData_q <= wrData_d;
            wrStb_q <= wrStb_d;
            rdStb_q <= rdStb_d;
            out_q <= out_d;
            oeN_q <= oeN_d;
        end
    end

    assign mdioOut = out_q;
    assign mdioOeN = oeN_q;
    assign regAddr = addr_q;
    assign regRdStrobe = rdStb_q;
    assign regWrData = wrData_q;
    assign regWrStrobe = wrStb_q;
    assign phyAddress = strap_q;
    assign deviceReady = ready_q;
endmodule // mpsl_mgmt_top

/* File: testbench/mpsl_mgmt_props.sv */
/* Checker on the ports of mpsl_mgmt_top.
   Assumes it is bound to every instance of that module. */
`timescale 1ns/1ps
module mpsl_mgmt_props (
    // watched ports
    input wire clk_sys,
    input wire srst,
    input wire mdioOut,
    input wire mdioOeN,
    input wire linkIndicatorOut,
    input wire linkIndicatorOeN,
    input wire activityIndicatorOut,
    input wire activityIndicatorOeN,
    input wire linkGood,
    input wire txActive,
    input wire rxActive,
    input wire regRdStrobe,
    input wire regWrStrobe,
    input wire [4:0] phyAddress,
    input wire deviceReady
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_rst;
        $fell(srst) |-> !deviceReady && mdioOeN && linkIndicatorOeN;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_idle;
        !deviceReady |-> mdioOeN && !regRdStrobe && !regWrStrobe;
    endproperty
    a_idle: assert property (p_idle) else $error("early frame");
    property p_addr;
        deviceReady && $past(deviceReady) |-> $stable(phyAddress);
    endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_oe;
        deviceReady |=> !linkIndicatorOeN && !activityIndicatorOeN;
    endproperty
    a_oe: assert property (p_oe) else $error("indicator idle");
    property p_link;
        !linkIndicatorOeN |->
            linkIndicatorOut == ($past(linkGood) ^ phyAddress[0]);
    endproperty
    a_link: assert property (p_link) else $error("link ind");
    property p_act;
        !activityIndicatorOeN |-> activityIndicatorOut ==
            (($past(txActive) | $past(rxActive)) ^ phyAddress[1]);
    endproperty
    a_act: assert property (p_act) else $error("activity ind");
    property p_ta;
        $fell(mdioOeN) |-> !mdioOut ##1 !mdioOeN [*4];
    endproperty
    a_ta: assert property (p_ta) else $error("turnaround");
    property p_rd;
        regRdStrobe |-> ##[2:200] $fell(mdioOeN);
    endproperty
    a_rd: assert property (p_rd) else $error("no read drive");
endmodule // mpsl_mgmt_props

bind mpsl_mgmt_top mpsl_mgmt_props u_props (
    .clk_sys(clk_sys),
    .srst(srst),
    .mdioOut(mdioOut),
    .mdioOeN(mdioOeN),
    .linkIndicatorOut(linkIndicatorOut),
    .linkIndicatorOeN(linkIndicatorOeN),
    .activityIndicatorOut(activityIndicatorOut),
    .activityIndicatorOeN(activityIndicatorOeN),
    .linkGood(linkGood),
    .txActive(txActive),
    .rxActive(rxActive),
    .regRdStrobe(regRdStrobe),
    .regWrStrobe(regWrStrobe),
    .phyAddress(phyAddress),
    .deviceReady(deviceReady)
);

/* File: testbench/mpsl_sta_model.sv */
/* Station management controller model: mdc and mdio drive.
   Assumes the bench resolves the mdio wire with its pull-up. */
`timescale 1ns/1ps
module mpsl_sta_model (
    // management pins
    output reg mdc,
    output reg staOeN,
    output reg staOut,
    input wire mdioWire
);
    initial begin
        mdc = 1'b0;
        staOeN = 1'b1;
        staOut = 1'b1;
    end
    // mdc stands low between frames; 64 ns period keeps the run short
    task frame(input [31:0] bits, input integer nDrv, output [32:0] got);
        integer i;
        begin
            #1.3;
            for (i = 0; i < 33; i = i + 1) begin
                staOeN = i >= nDrv;
                staOut = bits[31 - i % 32];
                #32 mdc = 1'b1;
                got[32 - i] = mdioWire;
                #32 mdc = 1'b0;
            end
            staOeN = 1'b1;
        end
    endtask
endmodule // mpsl_sta_model

/* File: testbench/test_mpsl_mgmt_top.sv */
/* Bench for mpsl_mgmt_top: resets, strap capture, indicators, frames.
   Assumes the controller model and the checker are compiled first. */
`timescale 1ns/1ps
module test_mpsl_mgmt_top;
    reg clk_sys, srst, linkGood, txActive, rxActive, speed100, fullDuplex;
    reg [15:0] regRdData, lfsr;
    reg [4:0] strap;
    reg [3:0] evQ;
    reg [32:0] got;
    reg hit;
    wire mdcIn, staOeN, staOut, mdioOut, mdioOeN, regRdStrobe, regWrStrobe;
    wire deviceReady, linkIndicatorOut, linkIndicatorOeN;
    wire activityIndicatorOut, activityIndicatorOeN, speedIndicatorOut;
    wire speedIndicatorOeN, duplexIndicatorOut, duplexIndicatorOeN;
    wire [4:0] regAddr, phyAddress;
    wire [15:0] regWrData;
    // released pins fall back to the pull-up or the strap resistor
    wire mdioIn = !mdioOeN ? mdioOut : !staOeN ? staOut : 1'b1;
    wire linkIndicatorIn = linkIndicatorOeN ? strap[0] : linkIndicatorOut;
    wire activityIndicatorIn =
        activityIndicatorOeN ? strap[1] : activityIndicatorOut;
    wire speedIndicatorIn = speedIndicatorOeN ? strap[2] : speedIndicatorOut;
    wire duplexIndicatorIn =
        duplexIndicatorOeN ? strap[3] : duplexIndicatorOut;
    wire phyAddrStrap4In = strap[4];
    integer miscompares = 0, n_compared = 0, nWr = 0, nRd = 0;
    integer i, k, r, w0, r0;

    mpsl_mgmt_top #(.RST_WAIT_CYC(20)) uut (
        .clk_sys(clk_sys),
        .srst(srst),
        .mdcIn(mdcIn),
        .mdioIn(mdioIn),
        .mdioOut(mdioOut),
        .mdioOeN(mdioOeN),
        .linkIndicatorIn(linkIndicatorIn),
        .activityIndicatorIn(activityIndicatorIn),
        .speedIndicatorIn(speedIndicatorIn),
        .duplexIndicatorIn(duplexIndicatorIn),
        .phyAddrStrap4In(phyAddrStrap4In),
        .linkIndicatorOut(linkIndicatorOut),
        .linkIndicatorOeN(linkIndicatorOeN),
        .activityIndicatorOut(activityIndicatorOut),
        .activityIndicatorOeN(activityIndicatorOeN),
        .speedIndicatorOut(speedIndicatorOut),
        .speedIndicatorOeN(speedIndicatorOeN),
        .duplexIndicatorOut(duplexIndicatorOut),
        .duplexIndicatorOeN(duplexIndicatorOeN),
        .linkGood(linkGood),
        .txActive(txActive),
        .rxActive(rxActive),
        .speed100(speed100),
        .fullDuplex(fullDuplex),
        .regAddr(regAddr),
        .regRdStrobe(regRdStrobe),
        .regRdData(regRdData),
        .regWrData(regWrData),
        .regWrStrobe(regWrStrobe),
        .phyAddress(phyAddress),
        .deviceReady(deviceReady)
    );
    mpsl_sta_model sta (.mdc(mdcIn), .staOeN(staOeN), .staOut(staOut),
        .mdioWire(mdioIn));

    function [15:0] nextRand(input [15:0] v);
        nextRand = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task tally(input ok, input [17:0] g, input [17:0] e);
        begin
            n_compared = n_compared + 1;
            if (!ok) begin
                miscompares = miscompares + 1;
                $display("BAD %0t got %h exp %h", $time, g, e);
            end
        end
    endtask

    // bits seen on the management line by the controller
    task chkLine(input [17:0] g, input [17:0] e);
        tally(g === e, g, e);
    endtask

    // register side results, counts and captured address
    task chkReg(input [15:0] g, input [15:0] e);
        tally(g === e, {2'h0, g}, {2'h0, e});
    endtask

    // indicator pin levels
    task chkInd(input g, input e);
        tally(g === e, {17'h00000, g}, {17'h00000, e});
    endtask

    task wrap_up;
        begin
            $display("compared %0d bad %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task doReset(input [4:0] s);
        begin
            srst <= 1'b1;
            @(posedge clk_sys);
            strap <= s;
            repeat (11) @(posedge clk_sys);
            srst <= 1'b0;
            for (i = 0; i < 100 && deviceReady !== 1'b1; i = i + 1)
                @(posedge clk_sys);
            if (deviceReady !== 1'b1) begin
                miscompares = miscompares + 1;
                wrap_up;
            end
            @(negedge clk_sys);
            chkReg(phyAddress, strap);
        end
    endtask

    // read hits and writes leave TA 10 plus data on the wire
    task mgmt(input [1:0] op, input [4:0] pa);
        reg [15:0] d;
        reg [4:0] ra;
        begin
            d = lfsr;
            ra = lfsr[12:8];
            hit = pa == strap && (op == 2'h1 || op == 2'h2);
            w0 = nWr;
            r0 = nRd;
            regRdData <= d;
            sta.frame({2'h1, op, pa, ra, 2'h2, d}, op == 2'h2 ? 14 : 32, got);
            @(posedge clk_sys);
            // rise i lands in got[32-i]: rises 14..31 carry TA and data
            chkLine(got[18:1], op == 2'h2 && !hit ? 18'h3FFFF : {2'h2, d});
            chkReg(nWr - w0, hit && op == 2'h1);
            chkReg(nRd - r0, hit && op == 2'h2);
            if (hit) chkReg(regAddr, ra);
            if (hit && op == 2'h1) chkReg(regWrData, d);
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        lfsr <= nextRand(lfsr);
        {linkGood, txActive, rxActive, speed100, fullDuplex} <= lfsr[4:0];
        evQ <= {fullDuplex & linkGood, speed100, txActive | rxActive, linkGood};
        if (regWrStrobe === 1'b1) nWr <= nWr + 1;
        if (regRdStrobe === 1'b1) nRd <= nRd + 1;
    end

    always @(negedge clk_sys) begin
        if (linkIndicatorOeN === 1'b0)
            chkInd(linkIndicatorOut, evQ[0] ^ strap[0]);
        if (activityIndicatorOeN === 1'b0)
            chkInd(activityIndicatorOut, evQ[1] ^ strap[1]);
        if (speedIndicatorOeN === 1'b0)
            chkInd(speedIndicatorOut, evQ[2] ^ strap[2]);
        if (duplexIndicatorOeN === 1'b0)
            chkInd(duplexIndicatorOut, evQ[3] ^ strap[3]);
    end

    initial begin
        srst = 1'b1;
        lfsr = 16'h0028;
        {linkGood, txActive, rxActive, speed100, fullDuplex} = 5'h00;
        regRdData = 16'h0000;
        strap = 5'h00;
        for (r = 0; r < 2; r = r + 1) begin
            doReset(r == 0 ? lfsr[4:0] : ~strap);
            for (k = 0; k < 12; k = k + 1) begin
                @(posedge clk_sys);
                mgmt(k[1:0], k % 3 ? strap : strap ^ (5'h01 << k % 5));
            end
        end
        wrap_up;
    end
endmodule // test_mpsl_mgmt_top
